// *** test/tmr2_pins.sv ***
// Purpose: far-side model of the timer 2 pins: trigger, clock pin, timer 1 baud ticks
// Assumes: trigger level moved by the bench only through set_trig
// Notes:   released clock pin shows the outside level, high by its pull-up unless driven
`default_nettype none
module tmr2_pins (
   input  wire logic MCLK,     // clock
   input  wire logic RESETN,   // sync reset, low
   input  wire logic CLKIO_O,  // block drive value
   input  wire logic CLKIO_OE, // block drive enable
   output logic      TRIG_I,   // trigger level
   output logic      CLKIO_I,  // resolved clock pin level
   output logic      T1_TX_I,  // timer 1 tx tick
   output logic      T1_RX_I   // timer 1 rx tick
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] div_q;
   logic       trig_q = 1'b1;
   logic       ext_q  = 1'b1;
   // ----------------------------------------
   // timer 1 ticks, one clock wide, every 32 clocks
   // ----------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RESETN) div_q <= 5'h00;
      else div_q <= div_q + 5'h01;
   end
   assign T1_TX_I = (div_q == 5'h07);
   assign T1_RX_I = (div_q == 5'h13);
   assign TRIG_I  = trig_q;
   assign CLKIO_I = CLKIO_OE ? CLKIO_O : ext_q;
   // level changes only after an edge; bench keeps each level >= 12 clocks
   task automatic set_trig(input logic v);
      @(posedge MCLK);
      trig_q <= v;
   endtask
   // outside source on the clock pin, seen only while the block does not drive it
   task automatic set_clk(input logic v);
      @(posedge MCLK);
      ext_q <= v;
   endtask
endmodule
`default_nettype wire

// *** test/tmr2_top_tb.sv ***
// Purpose: self-checking bench for the timer 2 block over its wishbone port
// Assumes: one-cycle registered ack, timer at MCLK/6, baud and clock-out at MCLK
// Notes:   ranges allow one tick of phase slack between bench and block
`default_nettype none
`include "tmr2_map.svh"
module tmr2_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic MCLK = 1'b0, RESETN = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, clko_prev = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat;
   wire logic [31:0] dat_o;
   wire logic ack, trig, clkio_i, clko, clkoe, t1tx, t1rx, txb, rxb, irq;
   int errors = 0, compares = 0, tx_n = 0, rx_n = 0, t1_n = 0, tog_n = 0, s_tx, s_rx, s_t1;
   always #2 MCLK = ~MCLK;
   always @(posedge MCLK) begin
      tx_n += int'(txb === 1'b1);
      rx_n += int'(rxb === 1'b1);
      t1_n += int'(t1rx === 1'b1);
      tog_n += int'(clko !== clko_prev);
      clko_prev = clko;
   end
   tmr2_top tmr2_top_i (.MCLK(MCLK), .RESETN(RESETN), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack), .TRIG_I(trig), .CLKIO_I(clkio_i), .CLKIO_O(clko), .CLKIO_OE(clkoe),
      .T1_TX_I(t1tx), .T1_RX_I(t1rx), .TX_BAUD_O(txb), .RX_BAUD_O(rxb), .IRQ_O(irq));
   tmr2_pins tmr2_pins_i (.MCLK(MCLK), .RESETN(RESETN), .CLKIO_O(clko), .CLKIO_OE(clkoe),
      .TRIG_I(trig), .CLKIO_I(clkio_i), .T1_TX_I(t1tx), .T1_RX_I(t1rx));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic print_verdict;
      if (errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // request held until ack is sampled high; read data taken at that edge
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge MCLK);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; wdat <= d;
      n = 0;
      do begin
         @(posedge MCLK);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rdat = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (ack !== 1'b1) begin
         errors++;
         print_verdict();
      end
   endtask
   task automatic setup(input logic [7:0] c, input logic [7:0] m, input logic [15:0] cnt,
                        input logic [15:0] rl);
      wb(`TMR2_OFS_CTRL, 1'b1, 32'h0); // stop before touching count/reload
      wb(`TMR2_OFS_MODE, 1'b1, {24'h0, m});
      wb(`TMR2_OFS_COUNT, 1'b1, {16'h0, cnt});
      wb(`TMR2_OFS_RELOAD, 1'b1, {16'h0, rl});
      wb(`TMR2_OFS_CTRL, 1'b1, {24'h0, c});
   endtask
   // one falling edge, then back high; edges far apart so each is serviced first
   task automatic trig_fall;
      tmr2_pins_i.set_trig(1'b0);
      repeat (12) @(posedge MCLK);
      tmr2_pins_i.set_trig(1'b1);
   endtask
   task automatic wait_irq;
      for (int n = 0; n < 400 && irq !== 1'b1; n++) @(posedge MCLK);
      check({31'h0, irq}, 32'h1);
      if (irq !== 1'b1) print_verdict();
   endtask
   task automatic rd(input logic [3:0] a);
      wb(a, 1'b0, 32'h0);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge MCLK);
      RESETN <= 1'b1;
      rd(`TMR2_OFS_CTRL); check(rdat, 32'h0);
      rd(`TMR2_OFS_MODE); check(rdat, 32'h0);
      rd(4'h2); check(rdat, 32'h0);
      wb(`TMR2_OFS_COUNT, 1'b1, 32'h42);
      repeat (30) @(posedge MCLK);
      rd(`TMR2_OFS_COUNT); check(rdat, 32'h42);
      // capture, trigger ignored: plain timer wrapping to 0
      setup(8'h05, 8'h00, 16'hfffe, 16'h1111);
      trig_fall();
      wait_irq();
      rd(`TMR2_OFS_CTRL); check({30'h0, rdat[7:6]}, 32'h2);
      rd(`TMR2_OFS_COUNT); check({31'h0, rdat[15:0] < 16'h0100}, 32'h1);
      rd(`TMR2_OFS_RELOAD); check(rdat, 32'h1111);
      // capture with trigger
      setup(8'h0d, 8'h00, 16'h0500, 16'haaaa);
      trig_fall();
      wait_irq();
      rd(`TMR2_OFS_CTRL); check({30'h0, rdat[7:6]}, 32'h1);
      rd(`TMR2_OFS_RELOAD); check({24'h0, rdat[15:8]}, 32'h05);
      rd(`TMR2_OFS_COUNT); check({24'h0, rdat[15:8]}, 32'h05);
      // reload on trigger edge
      setup(8'h0c, 8'h00, 16'h0100, 16'h1234);
      trig_fall();
      wait_irq();
      rd(`TMR2_OFS_CTRL); check({30'h0, rdat[7:6]}, 32'h1);
      rd(`TMR2_OFS_COUNT); check({24'h0, rdat[15:8]}, 32'h12);
      // up-count overflow reload
      setup(8'h04, 8'h00, 16'hfffe, 16'hfff0);
      wait_irq();
      rd(`TMR2_OFS_CTRL); check({30'h0, rdat[7:6]}, 32'h2);
      rd(`TMR2_OFS_COUNT); check({31'h0, rdat[15:0] >= 16'hfff0}, 32'h1);
      // counter select: three pin falls from fffd overflow and reload 0
      setup(8'h06, 8'h00, 16'hfffd, 16'h0000);
      repeat (3) begin
         tmr2_pins_i.set_clk(1'b0);
         repeat (12) @(posedge MCLK);
         tmr2_pins_i.set_clk(1'b1);
         repeat (12) @(posedge MCLK);
      end
      rd(`TMR2_OFS_CTRL); check({30'h0, rdat[7:6]}, 32'h2);
      rd(`TMR2_OFS_COUNT); check(rdat, 32'h0);
      // up/down with pin high
      setup(8'h04, 8'h01, 16'hfffe, 16'hfff0);
      wait_irq();
      rd(`TMR2_OFS_CTRL); check({30'h0, rdat[7:6]}, 32'h3);
      rd(`TMR2_OFS_COUNT); check({31'h0, rdat[15:0] >= 16'hfff0}, 32'h1);
      // up/down with pin low: underflow at reload value
      tmr2_pins_i.set_trig(1'b0);
      setup(8'h04, 8'h01, 16'h0012, 16'h0010);
      wait_irq();
      rd(`TMR2_OFS_CTRL); check({30'h0, rdat[7:6]}, 32'h3);
      rd(`TMR2_OFS_COUNT); check({24'h0, rdat[15:8]}, 32'hff);
      tmr2_pins_i.set_trig(1'b1);
      // flags hold while stopped, cleared only by a write
      wb(`TMR2_OFS_CTRL, 1'b1, 32'hc0);
      repeat (50) @(posedge MCLK);
      rd(`TMR2_OFS_CTRL); check(rdat, 32'hc0);
      wb(`TMR2_OFS_CTRL, 1'b1, 32'h0);
      repeat (3) @(posedge MCLK);
      rd(`TMR2_OFS_CTRL); check(rdat, 32'h0);
      check({31'h0, irq}, 32'h0);
      // baud: tx from timer 2 with capture select set, rx from timer 1
      setup(8'h1d, 8'h00, 16'hfffe, 16'hfffe);
      s_tx = tx_n; s_rx = rx_n; s_t1 = t1_n;
      repeat (320) @(posedge MCLK);
      check({31'h0, (tx_n - s_tx) inside {[9:11]}}, 32'h1);
      check({31'h0, (rx_n - s_rx - t1_n + s_t1) inside {[-1:1]}}, 32'h1);
      trig_fall();
      wait_irq();
      rd(`TMR2_OFS_CTRL); check({30'h0, rdat[7:6]}, 32'h1);
      // clock-out: counter select clear, output enable and run set
      setup(8'h04, 8'h02, 16'hfffc, 16'hfffc);
      repeat (4) @(posedge MCLK);
      s_tx = tog_n; s_rx = tx_n; s_t1 = t1_n;
      repeat (80) @(posedge MCLK);
      check({31'h0, (tx_n - s_rx - t1_n + s_t1) inside {[-1:1]}}, 32'h1);
      check({31'h0, clkoe}, 32'h1);
      check({31'h0, (tog_n - s_tx) inside {[19:21]}}, 32'h1);
      rd(`TMR2_OFS_CTRL); check({30'h0, rdat[7:6]}, 32'h0);
      check({31'h0, irq}, 32'h0);
      wb(`TMR2_OFS_CTRL, 1'b1, 32'h0);
      print_verdict();
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge MCLK);
      errors++;
      print_verdict();
   end
endmodule
`default_nettype wire

// *** verilog/tmr2_edge.sv ***
// Purpose: falling edge finder for the trigger pin, sampled per machine cycle
// Assumes: pin synchronous to the clock
// Notes:   high one sample, low the next, pulse on the third cycle
`default_nettype none
module tmr2_edge (
   input  wire logic MCLK,     // clock
   input  wire logic RESETN,   // sync reset, low
   input  wire logic tick,     // machine cycle strobe
   input  wire logic pin,      // trigger level
   output logic      fall      // one-cycle pulse
);
   logic prev_q;
   logic cur_q;

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         prev_q <= 1'b0;
         cur_q  <= 1'b0;
      end else if (tick) begin
         prev_q <= cur_q;
         cur_q  <= pin;
      end
   end

   // pulse on the tick after the low sample; a registered copy would miss that tick
   assign fall = tick & prev_q & ~cur_q;
endmodule
`default_nettype wire

// *** verilog/tmr2_map.svh ***
// Purpose: offsets, fields, reset values and counts of the timer 2 block
// Assumes: classic wishbone, 32-bit data, word offsets
// Notes:   definitions only
`ifndef TMR2_MAP_SVH
`define TMR2_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TMR2_OFS_CTRL     4'h0
`define TMR2_OFS_MODE     4'h4
`define TMR2_OFS_COUNT    4'h8
`define TMR2_OFS_RELOAD   4'hc
// ----------------------------------------
// control and mode field positions
// ----------------------------------------
`define TMR2_B_OVF        7
`define TMR2_B_EXTF       6
`define TMR2_B_RXSEL      5
`define TMR2_B_TXSEL      4
`define TMR2_B_EXEN       3
`define TMR2_B_RUN        2
`define TMR2_B_CTSEL      1
`define TMR2_B_CAPSEL     0
`define TMR2_B_CLKOE      1
`define TMR2_B_DOWN_COUNT_ENABLE       0
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define TMR2_CTRL_RST     8'h00
`define TMR2_MODE_RST     8'h00
`define TMR2_CNT_MAX      16'hffff
`define TMR2_MC_CLKS      3'h6
`define TMR2_BAUD_DIV     4'hf
`endif

// *** verilog/tmr2_pkg.sv ***
// Purpose: types shared by the timer 2 files
// Assumes: nothing beyond the map header
// Notes:   the package holds types only
`default_nettype none
package tmr2_pkg;
   typedef struct packed {
      logic ovf;
      logic extf;
      logic rxsel;
      logic txsel;
      logic exen;
      logic run;
      logic ctsel;
      logic capsel;
   } tmr2_ctrl_t;
   typedef enum logic [1:0] {
      TMR2_OFF,
      TMR2_CAPTURE,
      TMR2_RELOAD,
      TMR2_BAUD
   } tmr2_mode_t;
endpackage
`default_nettype wire

// *** verilog/tmr2_top.sv ***
// Purpose: third 16-bit timer/counter with capture, reload, clock-out and baud modes
// Assumes: classic wishbone slave, pins synchronous to MCLK, 6 clocks per machine cycle
// Notes:   registers at word offsets, single-cycle ack
//
// Summary of operation
// R1: capture mode without trigger: plain 16-bit timer/counter, overflow sets flag.
// R2: capture mode with trigger: falling edge copies count into reload registers.
// R3: qualifying edge sets ext flag; both flags drive shared interrupt request.
// R4: capture mode never reloads the counter; counting continues.
// R5: software services each capture before the next trigger edge.
// R6: down count enable resets to 0; when set, pin level selects direction.
// R7: counting up reaches ffff, overflow sets flag and loads reload value.
// R8: reload mode with trigger, no down count: edge reloads and sets ext flag.
// R9: edge recognition: high sample, low sample, flag set third machine cycle.
// R10: up/down with pin high counts up, overflow at ffff reloads, sets flag.
// R11: pin low counts down; equal to reload underflows, loads ffff, sets flag.
// R12: in up/down mode ext flag toggles on each overflow or underflow.
// R13: software clears counter select, sets clock enable and run for clock-out.
// R14: clock-out toggles pin on each roll-over, giving osc/(2*(65536-reload)).
// R15: clock-out roll-overs raise no interrupt.
// R16: tx and rx select bits pick timer 2 or timer 1 baud source independently.
// R17: baud mode roll-over reloads the 16-bit counter from reload registers.
// R18: baud mode with internal clock counts every oscillator clock.
// R19: uart baud tick equals timer 2 overflow rate divided by 16.
// R20: baud mode roll-over sets no overflow flag and requests no interrupt.
// R21: baud mode trigger edge sets ext flag without reloading.
// R22: software stops the timer before touching counter or reload registers.
// R23: flags stay set until software clears them; a set wins over a clear.
// R24: any baud select forces auto-reload, ignoring capture select.
// R25: the timer runs only while run control is set.
`default_nettype none
`include "tmr2_map.svh"
module tmr2_top (
   input  wire logic        MCLK,      // 250 MHz clock
   input  wire logic        RESETN,    // sync reset, low
   input  wire logic        WB_CYC_I,  // bus cycle
   input  wire logic        WB_STB_I,  // strobe
   input  wire logic        WB_WE_I,   // write
   input  wire logic [3:0]  WB_ADR_I,  // byte address
   input  wire logic [3:0]  WB_SEL_I,  // byte lanes
   input  wire logic [31:0] WB_DAT_I,  // write data
   output logic      [31:0] WB_DAT_O,  // read data
   output logic             WB_ACK_O,  // ack
   input  wire logic        TRIG_I,    // ext trigger pin level
   input  wire logic        CLKIO_I,   // clock io pin level
   output logic             CLKIO_O,   // clock io pin drive value
   output logic             CLKIO_OE,  // clock io pin drive enable
   input  wire logic        T1_TX_I,   // timer 1 tx baud tick
   input  wire logic        T1_RX_I,   // timer 1 rx baud tick
   output logic             TX_BAUD_O, // uart tx baud tick
   output logic             RX_BAUD_O, // uart rx baud tick
   output logic             IRQ_O      // shared timer 2 request
);
   tmr2_pkg::tmr2_ctrl_t ctrl_q;
   logic [1:0]   tmod_q;
   logic [15:0]  cnt_q;
   logic [15:0]  rld_q;
   logic [2:0]   mc_q;
   logic         mc_tick;
   logic         fall;
   logic         pin_q;
   logic         pin_fall;
   logic         clk_q;
   logic [3:0]   div_q;
   logic         ovf_pulse_q;
   logic         div_tick;
   tmr2_pkg::tmr2_mode_t mode;
   logic         baud_any;
   logic         clkout;
   logic         inc;
   logic         up;
   logic         roll;
   logic         wr;
   logic         rd;

   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   assign baud_any = ctrl_q.rxsel | ctrl_q.txsel;
   assign clkout   = tmod_q[`TMR2_B_CLKOE] & ~ctrl_q.ctsel & ~baud_any;
   always_comb begin
      if (!ctrl_q.run) begin
         mode = tmr2_pkg::TMR2_OFF;                          // [R25]
      end else if (baud_any) begin
         mode = tmr2_pkg::TMR2_BAUD;                         // [R24]
      end else if (ctrl_q.capsel && !clkout) begin
         mode = tmr2_pkg::TMR2_CAPTURE;
      end else begin
         mode = tmr2_pkg::TMR2_RELOAD;
      end
   end

   // ----------------------------------------
   // count sources
   // ----------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RESETN || mc_q == `TMR2_MC_CLKS - 3'h1) begin
         mc_q <= 3'h0;
      end else begin
         mc_q <= mc_q + 3'h1;
      end
   end
   assign mc_tick = (mc_q == 3'h0);

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= CLKIO_I;
      end
   end
   // counter input disabled while the pin is driven out
   assign pin_fall = pin_q & ~CLKIO_I & ~clkout;

   tmr2_edge u_edge (
      .MCLK   (MCLK),
      .RESETN (RESETN),
      .tick   (mc_tick),
      .pin    (TRIG_I),
      .fall   (fall)                                       // [R9]
   );

   always_comb begin
      if (mode == tmr2_pkg::TMR2_OFF) begin
         inc = 1'b0;
      end else if (ctrl_q.ctsel) begin
         inc = pin_fall;                                     // [R1]
      end else if (mode == tmr2_pkg::TMR2_BAUD || clkout) begin
         inc = 1'b1;                                         // [R18]
      end else begin
         inc = mc_tick;
      end
   end
   // direction by pin only in plain reload mode with down count
   assign up   = !(mode == tmr2_pkg::TMR2_RELOAD && tmod_q[`TMR2_B_DOWN_COUNT_ENABLE] && !clkout
                   && !TRIG_I);                              // [R6]
   assign roll = inc && (up ? (cnt_q == `TMR2_CNT_MAX) : (cnt_q == rld_q));

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O;
   assign rd = WB_CYC_I & WB_STB_I & ~WB_WE_I & ~WB_ACK_O;

   // ----------------------------------------
   // counter
   // ----------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         cnt_q <= 16'h0000;
      end else if (wr && WB_ADR_I == `TMR2_OFS_COUNT) begin
         if (WB_SEL_I[0]) cnt_q[7:0]  <= WB_DAT_I[7:0];
         if (WB_SEL_I[1]) cnt_q[15:8] <= WB_DAT_I[15:8];
      end else if (roll) begin
         unique case (mode)
            tmr2_pkg::TMR2_CAPTURE: cnt_q <= 16'h0000;       // [R4]
            tmr2_pkg::TMR2_BAUD:    cnt_q <= rld_q;          // [R17]
            tmr2_pkg::TMR2_RELOAD:  cnt_q <= up ? rld_q : `TMR2_CNT_MAX; // [R7] [R10] [R11] [R14]
            tmr2_pkg::TMR2_OFF:     cnt_q <= cnt_q;
         endcase
      end else if (mode == tmr2_pkg::TMR2_RELOAD && ctrl_q.exen && fall
                   && !tmod_q[`TMR2_B_DOWN_COUNT_ENABLE] && !clkout) begin
         cnt_q <= rld_q;                                     // [R8]
      end else if (inc) begin
         cnt_q <= up ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
      end
   end

   // ----------------------------------------
   // reload / capture register
   // ----------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         rld_q <= 16'h0000;
      end else if (mode == tmr2_pkg::TMR2_CAPTURE && ctrl_q.exen && fall) begin
         rld_q <= cnt_q;                                     // [R2] [R5]
      end else if (wr && WB_ADR_I == `TMR2_OFS_RELOAD) begin
         // writes in baud mode may collide with a reload [R22]
         if (WB_SEL_I[0]) rld_q[7:0]  <= WB_DAT_I[7:0];
         if (WB_SEL_I[1]) rld_q[15:8] <= WB_DAT_I[15:8];
      end
   end

   // ----------------------------------------
   // control, mode bits and flags
   // ----------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         ctrl_q <= `TMR2_CTRL_RST;
         tmod_q <= 2'b00;                                    // [R6]
      end else begin
         if (wr && WB_ADR_I == `TMR2_OFS_CTRL && WB_SEL_I[0]) begin
            ctrl_q <= WB_DAT_I[7:0];
         end
         if (wr && WB_ADR_I == `TMR2_OFS_MODE && WB_SEL_I[0]) begin
            tmod_q <= WB_DAT_I[1:0];
         end
         // hardware set wins over a software clear in the same cycle [R23]
         if (roll && (mode == tmr2_pkg::TMR2_CAPTURE
                      || (mode == tmr2_pkg::TMR2_RELOAD && !clkout))) begin
            ctrl_q.ovf <= 1'b1;                              // [R1] [R7] [R15] [R20]
         end
         if (roll && mode == tmr2_pkg::TMR2_RELOAD && tmod_q[`TMR2_B_DOWN_COUNT_ENABLE] && !clkout) begin
            ctrl_q.extf <= ~ctrl_q.extf;                     // [R12]
         end else if (fall && ctrl_q.exen && mode != tmr2_pkg::TMR2_OFF && !clkout
                      && !(mode == tmr2_pkg::TMR2_RELOAD && tmod_q[`TMR2_B_DOWN_COUNT_ENABLE])) begin
            ctrl_q.extf <= 1'b1;                             // [R3] [R21]
         end
      end
   end

   // ----------------------------------------
   // clock out and baud ticks
   // ----------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         clk_q    <= 1'b0;
         CLKIO_O  <= 1'b0;
         CLKIO_OE <= 1'b0;
      end else begin
         if (roll && clkout) begin
            clk_q <= ~clk_q;                                 // [R14]
         end
         CLKIO_O  <= clk_q;
         CLKIO_OE <= clkout;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         div_q       <= 4'h0;
         ovf_pulse_q <= 1'b0;
      end else begin
         ovf_pulse_q <= roll && mode == tmr2_pkg::TMR2_BAUD;
         if (roll && mode == tmr2_pkg::TMR2_BAUD) begin
            div_q <= (div_q == `TMR2_BAUD_DIV) ? 4'h0 : div_q + 4'h1; // [R19]
         end
      end
   end
   assign div_tick = ovf_pulse_q && (div_q == 4'h0);

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         TX_BAUD_O <= 1'b0;
         RX_BAUD_O <= 1'b0;
         IRQ_O     <= 1'b0;
      end else begin
         TX_BAUD_O <= ctrl_q.txsel ? div_tick : T1_TX_I;     // [R16]
         RX_BAUD_O <= ctrl_q.rxsel ? div_tick : T1_RX_I;     // [R16]
         IRQ_O     <= ctrl_q.ovf | ctrl_q.extf;              // [R3]
      end
   end

   // ----------------------------------------
   // bus answer
   // ----------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end else begin
         WB_ACK_O <= wr | rd;
         if (rd) begin
            unique case (WB_ADR_I)
               `TMR2_OFS_CTRL:   WB_DAT_O <= {24'h000000, ctrl_q};
               `TMR2_OFS_MODE:   WB_DAT_O <= {30'h0, tmod_q};
               `TMR2_OFS_COUNT:  WB_DAT_O <= {16'h0000, cnt_q};
               `TMR2_OFS_RELOAD: WB_DAT_O <= {16'h0000, rld_q};
               default:          WB_DAT_O <= 32'h00000000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_trig_fall;
      mc_tick && TRIG_I ##6 mc_tick && !TRIG_I;
   endsequence

   AST_RUN_OFF: assert property (@(posedge MCLK) disable iff (!RESETN) // [R25]
      !ctrl_q.run |=> $stable(cnt_q) || $past(wr)) else $error("counter moved while stopped");
   AST_UP_RELOAD: assert property (@(posedge MCLK) disable iff (!RESETN) // [R7]
      roll && up && mode == tmr2_pkg::TMR2_RELOAD && !wr |=> cnt_q == $past(rld_q))
      else $error("no reload on overflow");
   AST_DOWN_LOAD: assert property (@(posedge MCLK) disable iff (!RESETN) // [R11]
      roll && !up && !wr |=> cnt_q == 16'hffff) else $error("underflow did not load ffff");
   AST_OVF_SET: assert property (@(posedge MCLK) disable iff (!RESETN) // [R1]
      roll && mode == tmr2_pkg::TMR2_CAPTURE |=> ctrl_q.ovf) else $error("overflow flag missed");
   AST_BAUD_NOFLAG: assert property (@(posedge MCLK) disable iff (!RESETN) // [R20]
      roll && mode == tmr2_pkg::TMR2_BAUD && !ctrl_q.ovf && !wr |=> !ctrl_q.ovf)
      else $error("baud roll-over set overflow flag");
   AST_EDGE_FLAG: assert property (@(posedge MCLK) disable iff (!RESETN) // [R9]
      s_trig_fall ##0 (ctrl_q.exen && mode == tmr2_pkg::TMR2_CAPTURE && !wr)[*7]
      |=> ctrl_q.extf) else $error("ext flag not set by edge");
   AST_CAPTURE: assert property (@(posedge MCLK) disable iff (!RESETN) // [R2]
      fall && ctrl_q.exen && mode == tmr2_pkg::TMR2_CAPTURE |=> rld_q == $past(cnt_q))
      else $error("capture missed");
   AST_IRQ: assert property (@(posedge MCLK) disable iff (!RESETN) // [R3]
      ctrl_q.ovf || ctrl_q.extf |=> IRQ_O) else $error("request not raised");
   AST_CLKOUT_TOGGLE: assert property (@(posedge MCLK) disable iff (!RESETN) // [R14]
      roll && clkout |=> clk_q != $past(clk_q)) else $error("clock out did not toggle");
endmodule
`default_nettype wire
